/* logic/gled_top.sv */
`timescale 1ns/1ps
`include "gled_cfg.svh"
module gled_top #(
	parameter int SLOT_CYCLES = `GLED_SLOT_NS / `GLED_CLK_NS,
	parameter int SHIFT_HALF = (`GLED_SHIFT_HALF_NS + `GLED_CLK_NS - 1)
		/ `GLED_CLK_NS,
	parameter int MAX_LEDS = 16
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire gled_pkg::gled_addr_t addr_i,
	input wire gled_pkg::gled_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output gled_pkg::gled_word_t rdata_o,
	input wire logic display_request_input_i,
	input wire logic [6:0] relative_charge_percent_i,
	input wire logic [6:0] health_percent_i,
	input wire logic [15:0] gauge_flags_i,
	input wire logic charge_termination_i,
	input wire logic full_charge_clear_i,
	input wire logic rest_entry_i,
	input wire logic rest_voltage_done_i,
	input wire logic temp_measure_i,
	output logic shift_clock_pin_o,
	output logic shift_data_pin_o,
	output logic indicator_three_pin_o,
	output logic indicator_four_pin_o,
	output logic alert_port_modes_zero_one_o,
	output logic alert_port_mode_two_o,
	output logic alert_port_mode_two_oe_o,
	output logic alert_port_mode_three_o,
	output logic alert_port_mode_four_o,
	output logic scaled_units_o
);
	import gled_pkg::*;

	localparam int SW = $clog2(SLOT_CYCLES + 1);
	localparam int HW = $clog2(SHIFT_HALF + 1);

	if (SLOT_CYCLES < 2 || SHIFT_HALF < 1 || MAX_LEDS != 16) begin : g_chk
		$error("gled_top: unsupported parameter values");
	end

	//--------------------------------------------------------------
	// register file
	//--------------------------------------------------------------
	logic [7:0] ledcfg_reg;
	logic [15:0] mask_reg;
	logic [1:0] pack_reg;
	logic [7:0] hold_reg;
	logic [7:0] exthold_reg;
	logic [7:0] fcth_reg;
	logic [1:0] test_reg;
	logic [2:0] mode;
	logic always_on;
	logic ext_mode;
	logic [15:0] flags_eff;
	logic alert_act;

	assign mode = ledcfg_reg[2:0];
	assign ext_mode = (mode == `GLED_MODE_EXT2W)
		|| (mode == `GLED_MODE_EXT1W);
	// single-LED mode ignores the always-on bit
	assign always_on = ledcfg_reg[`GLED_F_ALWAYS]
		&& (mode != `GLED_MODE_SINGLE);

	// software writes; mode 0 and empty mask after reset
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ledcfg_reg <= `GLED_LEDCFG_RST;
			mask_reg <= `GLED_MASK_RST;
			pack_reg <= 2'h0;
			hold_reg <= `GLED_HOLD_RST;
			exthold_reg <= `GLED_HOLD_RST;
			fcth_reg <= `GLED_FCTH_RST;
			test_reg <= 2'h0;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				`GLED_A_LEDCFG: ledcfg_reg <= wdata_i[7:0];
				`GLED_A_MASK: mask_reg <= wdata_i;
				`GLED_A_PACK: pack_reg <= wdata_i[1:0];
				`GLED_A_HOLD: hold_reg <= wdata_i[7:0];
				`GLED_A_EXTHOLD: exthold_reg <= wdata_i[7:0];
				`GLED_A_FCTH: fcth_reg <= wdata_i[7:0];
				`GLED_A_TEST: test_reg <= wdata_i[1:0];
				default: ;
			endcase
		end
	end

	// scaled units is a pure notice bit for the host
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			scaled_units_o <= 1'b0;
		else if (ce_i)
			scaled_units_o <= pack_reg[`GLED_F_SCALED];
	end

	//--------------------------------------------------------------
	// time base: 7.8125 ms slots, 128 per second
	//--------------------------------------------------------------
	logic [SW-1:0] slot_cnt_reg;
	logic [6:0] phase_reg;
	logic slot_tick;
	logic sec_tick;

	assign slot_tick = slot_cnt_reg == SW'(SLOT_CYCLES - 1);
	assign sec_tick = slot_tick && (phase_reg == 7'h7F);

	// slot divider and phase within the 1 s period
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			slot_cnt_reg <= '0;
			phase_reg <= 7'h00;
		end else if (ce_i) begin
			if (slot_tick) begin
				slot_cnt_reg <= '0;
				phase_reg <= phase_reg + 7'h01;
			end else begin
				slot_cnt_reg <= slot_cnt_reg + SW'(1);
			end
		end
	end

	//--------------------------------------------------------------
	// button hold and display timer
	//--------------------------------------------------------------
	logic [7:0] press_cnt_reg;
	logic press_fire;
	logic [7:0] hold_cnt_reg;
	logic disp_on_reg;
	logic refresh_reg;
	logic was_always_reg;
	logic [7:0] hold_sel;
	logic disp_eff;

	// counted in slots, so the press lasts 1 s less a slot to 1 s
	assign press_fire = slot_tick && display_request_input_i
		&& (press_cnt_reg == `GLED_PRESS_SLOTS - 8'h01);
	assign hold_sel = ext_mode ? exthold_reg : hold_reg;
	assign disp_eff = test_reg[`GLED_F_TEST_EN]
		? test_reg[`GLED_F_TEST_ON] : disp_on_reg;

	// release of the request restarts the count
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			press_cnt_reg <= 8'h00;
		else if (ce_i) begin
			if (!display_request_input_i)
				press_cnt_reg <= 8'h00;
			else if (slot_tick && press_cnt_reg != `GLED_PRESS_SLOTS)
				press_cnt_reg <= press_cnt_reg + 8'h01;
		end
	end

	// on-time after a press, or refresh period when always on
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			disp_on_reg <= 1'b0;
			hold_cnt_reg <= 8'h00;
			refresh_reg <= 1'b0;
			was_always_reg <= 1'b0;
		end else if (ce_i) begin
			refresh_reg <= 1'b0;
			was_always_reg <= always_on;
			if (always_on) begin
				disp_on_reg <= 1'b1;
				if (sec_tick) begin
					if (hold_cnt_reg <= 8'h01) begin
						hold_cnt_reg <= hold_sel;
						refresh_reg <= 1'b1;
					end else begin
						hold_cnt_reg <= hold_cnt_reg - 8'h01;
					end
				end
			end else if (press_fire) begin
				disp_on_reg <= 1'b1;
				hold_cnt_reg <= hold_sel;
			end else if (was_always_reg) begin
				// leaving always-on must not leave a stale display lit
				disp_on_reg <= 1'b0;
			end else if (sec_tick && disp_on_reg) begin
				if (hold_cnt_reg <= 8'h01)
					disp_on_reg <= 1'b0;
				else
					hold_cnt_reg <= hold_cnt_reg - 8'h01;
			end
		end
	end

	//--------------------------------------------------------------
	// percent split over the LEDs
	//--------------------------------------------------------------
	logic [6:0] pct_raw;
	logic [6:0] pct;
	logic [6:0] single_pct;
	logic [4:0] led_count;
	logic [11:0] pct_scaled;
	logic [15:0] lit;

	assign pct_raw = pack_reg[`GLED_F_HEALTH]
		? health_percent_i : relative_charge_percent_i;
	assign pct = (pct_raw > `GLED_PCT_MAX) ? `GLED_PCT_MAX : pct_raw;
	assign single_pct = (pct > `GLED_SINGLE_MAX)
		? `GLED_SINGLE_MAX : pct;
	// reserved count 0 is taken as one LED
	assign led_count = ext_mode
		? 5'(ledcfg_reg[7:`GLED_F_CNT_LSB]) + 5'h01 : 5'h04;
	assign pct_scaled = 12'(pct) * 12'(led_count);

	// LED k lights once the share below it is exceeded (rounds up)
	for (genvar k = 0; k < MAX_LEDS; k++) begin : g_lit
		assign lit[k] = (5'(k) < led_count)
			&& (pct_scaled > 12'(100 * k));
	end

	//--------------------------------------------------------------
	// shift-chain driver
	//--------------------------------------------------------------
	gled_shift_t sh_state;
	logic [HW-1:0] sh_cnt_reg;
	logic [3:0] sh_idx_reg;
	logic [15:0] sh_data_reg;
	logic [15:0] sent_reg;
	logic sh_clk_reg;
	logic sh_dat_reg;
	logic [15:0] pattern;
	logic [3:0] top_idx;
	logic sh_go;
	logic half_done;

	assign pattern = disp_eff ? lit : 16'h0000;
	// one stage chain up to 8 LEDs, two beyond
	assign top_idx = (led_count > 5'h08) ? 4'hF : 4'h7;
	assign sh_go = ext_mode && (refresh_reg || pattern != sent_reg);
	assign half_done = sh_cnt_reg == HW'(SHIFT_HALF - 1);

	// farthest stage first; data moves on the falling edge
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sh_state <= SH_IDLE;
			sh_cnt_reg <= '0;
			sh_idx_reg <= 4'h0;
			sh_data_reg <= 16'h0000;
			sent_reg <= 16'h0000;
			sh_clk_reg <= 1'b0;
			sh_dat_reg <= 1'b0;
		end else if (ce_i) begin
			unique case (sh_state)
				SH_IDLE: begin
					if (sh_go) begin
						sh_data_reg <= pattern;
						sent_reg <= pattern;
						sh_idx_reg <= top_idx;
						sh_dat_reg <= pattern[top_idx];
						sh_cnt_reg <= '0;
						sh_state <= SH_LOW;
					end
				end
				SH_LOW: begin
					sh_cnt_reg <= half_done ? '0 : sh_cnt_reg + HW'(1);
					if (half_done) begin
						sh_clk_reg <= 1'b1;
						sh_state <= SH_HIGH;
					end
				end
				SH_HIGH: begin
					sh_cnt_reg <= half_done ? '0 : sh_cnt_reg + HW'(1);
					if (half_done) begin
						sh_clk_reg <= 1'b0;
						if (sh_idx_reg == 4'h0) begin
							sh_state <= SH_IDLE;
						end else begin
							sh_idx_reg <= sh_idx_reg - 4'h1;
							sh_dat_reg <= sh_data_reg[sh_idx_reg - 4'h1];
							sh_state <= SH_LOW;
						end
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// LED pins, registered
	//--------------------------------------------------------------
	logic [3:0] pins_next;

	always_comb begin
		pins_next = 4'h0;
		unique case (mode)
			`GLED_MODE_SINGLE:
				pins_next[0] = disp_eff && (phase_reg < single_pct);
			`GLED_MODE_FOUR:
				pins_next = disp_eff ? lit[3:0] : 4'h0;
			`GLED_MODE_EXT2W, `GLED_MODE_EXT1W:
				pins_next[1:0] = {sh_dat_reg, sh_clk_reg};
			default: pins_next = 4'h0;
		endcase
	end

	// pin order: led1 clock, led2 data, led3, led4
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			shift_clock_pin_o <= 1'b0;
			shift_data_pin_o <= 1'b0;
			indicator_three_pin_o <= 1'b0;
			indicator_four_pin_o <= 1'b0;
		end else if (ce_i) begin
			shift_clock_pin_o <= pins_next[0];
			shift_data_pin_o <= pins_next[1];
			indicator_three_pin_o <= pins_next[2];
			indicator_four_pin_o <= pins_next[3];
		end
	end

	//--------------------------------------------------------------
	// status flags kept here
	//--------------------------------------------------------------
	logic fc_reg;
	logic ocv_reg;
	logic full_charge_threshold;

	assign full_charge_threshold = (fcth_reg == 8'hFF) ? charge_termination_i
		: ({1'b0, pct_raw} > fcth_reg);

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			fc_reg <= 1'b0;
			ocv_reg <= 1'b0;
		end else if (ce_i) begin
			if (full_charge_threshold)
				fc_reg <= 1'b1;
			else if (full_charge_clear_i)
				fc_reg <= 1'b0;
			if (rest_voltage_done_i)
				ocv_reg <= 1'b1;
			else if (rest_entry_i)
				ocv_reg <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// alert
	//--------------------------------------------------------------
	always_comb begin
		flags_eff = gauge_flags_i & `GLED_FLAG_KEEP;
		flags_eff[`GLED_F_FC] = fc_reg;
		flags_eff[`GLED_F_OCV] = ocv_reg;
	end
	assign alert_act = |(flags_eff & mask_reg);

	// idle ports sit high; mode 2 pin lets go while sensing
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			alert_port_modes_zero_one_o <= 1'b1;
			alert_port_mode_two_o <= 1'b1;
			alert_port_mode_two_oe_o <= 1'b0;
			alert_port_mode_three_o <= 1'b1;
			alert_port_mode_four_o <= 1'b1;
		end else if (ce_i) begin
			alert_port_modes_zero_one_o <= !(alert_act
				&& (mode <= `GLED_MODE_SINGLE));
			alert_port_mode_two_o <= 1'b0;
			alert_port_mode_two_oe_o <= alert_act && !temp_measure_i
				&& (mode == `GLED_MODE_FOUR);
			alert_port_mode_three_o <= !(alert_act
				&& (mode == `GLED_MODE_EXT2W));
			alert_port_mode_four_o <= !(alert_act
				&& (mode == `GLED_MODE_EXT1W));
		end
	end

	//--------------------------------------------------------------
	// read port, data one cycle after the strobe
	//--------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			rdata_o <= 16'h0000;
		else if (ce_i) begin
			rdata_o <= 16'h0000;
			if (rd_i) begin
				unique case (addr_i)
					`GLED_A_LEDCFG: rdata_o <= {8'h00, ledcfg_reg};
					`GLED_A_MASK: rdata_o <= mask_reg;
					`GLED_A_PACK: rdata_o <= {14'h0000, pack_reg};
					`GLED_A_HOLD: rdata_o <= {8'h00, hold_reg};
					`GLED_A_EXTHOLD: rdata_o <= {8'h00, exthold_reg};
					`GLED_A_FCTH: rdata_o <= {8'h00, fcth_reg};
					`GLED_A_TEST: rdata_o <= {14'h0000, test_reg};
					`GLED_A_FLAGS: rdata_o <= flags_eff;
					`GLED_A_STATE: rdata_o <= {12'h000, alert_act,
						sh_state != SH_IDLE, disp_eff, disp_on_reg};
					default: rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	logic [4:0] pulse_cnt_reg;
	// clock pulses seen in the current shift frame
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || sh_state == SH_IDLE)
			pulse_cnt_reg <= 5'h00;
		else if (ce_i && sh_state == SH_LOW && half_done)
			pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
	end

	sequence s_frame_end;
		ce_i && sh_state == SH_HIGH && half_done && sh_idx_reg == 4'h0;
	endsequence
	sequence s_press_ok;
		ce_i && press_fire && !always_on;
	endsequence

	a_frame_bits: assert property (s_frame_end |->
		pulse_cnt_reg == 5'(top_idx) + 5'h01)
		else $error("shift frame bit count wrong");
	a_press_on: assert property (s_press_ok |=> disp_on_reg
		&& hold_cnt_reg == $past(hold_sel))
		else $error("press did not start display");
	a_always_lit: assert property (ce_i && always_on
		|=> disp_on_reg)
		else $error("always-on display not lit");
	a_single_cap: assert property (ce_i && mode == `GLED_MODE_SINGLE
		&& disp_eff && phase_reg >= 7'h5A |=> !shift_clock_pin_o)
		else $error("single LED lit above 90 slots");
	a_four_full: assert property (ce_i && mode == `GLED_MODE_FOUR
		&& disp_eff && pct > 7'h4B |=> indicator_four_pin_o
		&& indicator_three_pin_o)
		else $error("four LED pattern wrong");
	a_alert_zero: assert property (ce_i && alert_act
		&& mode == `GLED_MODE_NONE |=> !alert_port_modes_zero_one_o)
		else $error("alert not driven low");
	a_alert_idle: assert property (ce_i && !alert_act |=>
		alert_port_modes_zero_one_o && alert_port_mode_three_o
		&& alert_port_mode_four_o && !alert_port_mode_two_oe_o)
		else $error("alert driven without cause");
	a_fc_term: assert property (ce_i && fcth_reg == 8'hFF
		&& charge_termination_i |=> fc_reg)
		else $error("full charge flag not set");
	a_ocv_clear: assert property (ce_i && rest_entry_i
		&& !rest_voltage_done_i |=> !ocv_reg)
		else $error("rest voltage flag not cleared");
	a_mask_read: assert property (ce_i && rd_i && addr_i == `GLED_A_MASK
		|=> rdata_o == $past(mask_reg))
		else $error("mask read back wrong");
endmodule

/* shared/gled_cfg.svh */
`ifndef GLED_CFG_SVH
`define GLED_CFG_SVH
// register offsets
`define GLED_A_LEDCFG 4'h0
`define GLED_A_MASK 4'h1
`define GLED_A_PACK 4'h2
`define GLED_A_HOLD 4'h3
`define GLED_A_EXTHOLD 4'h4
`define GLED_A_FCTH 4'h5
`define GLED_A_TEST 4'h6
`define GLED_A_FLAGS 4'h7
`define GLED_A_STATE 4'h8
// reset values
`define GLED_LEDCFG_RST 8'h00
`define GLED_MASK_RST 16'h0000
`define GLED_HOLD_RST 8'h04
`define GLED_FCTH_RST 8'hFF
// field positions
`define GLED_F_ALWAYS 3
`define GLED_F_CNT_LSB 4
`define GLED_F_HEALTH 0
`define GLED_F_SCALED 1
`define GLED_F_TEST_EN 0
`define GLED_F_TEST_ON 1
`define GLED_F_FC 9
`define GLED_F_OCV 7
`define GLED_FLAG_KEEP 16'hFF97
// display modes
`define GLED_MODE_NONE 3'h0
`define GLED_MODE_SINGLE 3'h1
`define GLED_MODE_FOUR 3'h2
`define GLED_MODE_EXT2W 3'h3
`define GLED_MODE_EXT1W 3'h4
// timing
`define GLED_CLK_NS 10
`define GLED_SLOT_NS 7812500
`define GLED_SLOTS_PER_SEC 8'h80
`define GLED_PRESS_SLOTS 8'h80
`define GLED_SINGLE_MAX 7'h5A
`define GLED_PCT_MAX 7'h64
`define GLED_SHIFT_HALF_NS 500
`endif

/* shared/gled_pkg.sv */
package gled_pkg;
	typedef logic [3:0] gled_addr_t;
	typedef logic [15:0] gled_word_t;
	typedef enum logic [1:0] {
		SH_IDLE,
		SH_LOW,
		SH_HIGH
	} gled_shift_t;
endpackage

/* tb/gled_led_chain.sv */
`timescale 1ns/1ps
// ------------------------------------------
// two cascaded 8-stage serial-in registers
// ------------------------------------------
module gled_led_chain (
	input wire logic shift_clock_i,
	input wire logic shift_data_i,
	output logic [15:0] leds_o
);
	// shift on the rising clock; bit 0 holds the newest bit, and
	// the second stage takes the first stage's last output
	initial leds_o = 16'h0000;
	always @(posedge shift_clock_i) begin
		leds_o <= {leds_o[14:0], shift_data_i};
	end
endmodule

/* tb/gled_tb_top.sv */
`timescale 1ns/1ps
`include "gled_cfg.svh"
module gled_tb_top;
	import gled_pkg::*;
	// ------------------------------------------
	// stimulus, device and partner
	// ------------------------------------------
	logic sys_clk_i, srst_i, wr_i, rd_i, btn, term, fclr, rent, rdone, tmeas;
	gled_addr_t addr_i;
	gled_word_t wdata_i, rdata_o, flags_i;
	logic [6:0] chg, hlth;
	logic sclk, sdat, ind3, ind4, a01_n, a2, a2oe, a3_n, a4_n, scaled;
	logic [15:0] chain;
	int fail_count, num_checks;
	// shared pin has a pull-up, so released reads high
	wire a2_n = a2oe ? a2 : 1'b1;

	gled_top #(.SLOT_CYCLES(4), .SHIFT_HALF(2), .MAX_LEDS(16)) u_gled_top (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .display_request_input_i(btn),
		.relative_charge_percent_i(chg), .health_percent_i(hlth),
		.gauge_flags_i(flags_i), .charge_termination_i(term),
		.full_charge_clear_i(fclr), .rest_entry_i(rent),
		.rest_voltage_done_i(rdone), .temp_measure_i(tmeas),
		.shift_clock_pin_o(sclk), .shift_data_pin_o(sdat),
		.indicator_three_pin_o(ind3), .indicator_four_pin_o(ind4),
		.alert_port_modes_zero_one_o(a01_n), .alert_port_mode_two_o(a2),
		.alert_port_mode_two_oe_o(a2oe), .alert_port_mode_three_o(a3_n),
		.alert_port_mode_four_o(a4_n), .scaled_units_o(scaled));
	gled_led_chain u_gled_led_chain (.shift_clock_i(sclk),
		.shift_data_i(sdat), .leds_o(chain));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// ------------------------------------------
	// shared tasks
	// ------------------------------------------
	task automatic check(string what, logic [15:0] seen, logic [15:0] e);
		num_checks++;
		if (seen !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask
	// outputs are looked at mid-cycle, after the edge's updates land
	task automatic settle(int n);
		repeat (n) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic wr(gled_addr_t a, gled_word_t d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rchk(gled_addr_t a, gled_word_t e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		check("reg read", rdata_o, e);
	endtask
	task automatic pulse(logic [3:0] k);
		@(posedge sys_clk_i);
		{term, fclr, rent, rdone} <= k;
		@(posedge sys_clk_i);
		{term, fclr, rent, rdone} <= 4'h0;
	endtask
	// hold the button until the first led lights, or give up at lim
	task automatic press(int lim, output int n);
		@(posedge sys_clk_i);
		btn <= 1'b1;
		for (n = 0; n < lim && sclk !== 1'b1; n++) settle(0);
		@(posedge sys_clk_i);
		btn <= 1'b0;
	endtask
	// one whole second of the single-led cycle
	task automatic count_hi(output int n);
		n = 0;
		repeat (512) begin
			@(negedge sys_clk_i);
			if (sclk === 1'b1) n++;
		end
	endtask
	function automatic logic [3:0] leds4();
		return {ind4, ind3, sdat, sclk};
	endfunction

	// ------------------------------------------
	// scenarios
	// ------------------------------------------
	task automatic t_reset();
		rchk(`GLED_A_LEDCFG, 16'h0000);
		rchk(`GLED_A_MASK, 16'h0000);
		rchk(4'h9, 16'h0000);
		check("alert idle", 16'(a01_n), 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_alert();
		logic [3:0] e;
		@(posedge sys_clk_i);
		flags_i <= 16'h0001;
		for (int m = 0; m < 5; m++) begin
			wr(`GLED_A_LEDCFG, 16'(m));
			wr(`GLED_A_MASK, 16'h0001);
			settle(3);
			e = ~{m < 2, m == 2, m == 3, m == 4};
			check("ports", 16'({a01_n, a2_n, a3_n, a4_n}), 16'(e));
			wr(`GLED_A_MASK, 16'h0002);
			settle(3);
			check("ports off", 16'({a01_n, a2_n, a3_n, a4_n}), 16'hF);
		end
		wr(`GLED_A_LEDCFG, 16'h0002);
		wr(`GLED_A_MASK, 16'h0001);
		tmeas <= 1'b1;
		settle(3);
		check("temp share", 16'(a2_n), 16'h0001);
		wr(`GLED_A_LEDCFG, 16'h0000);
		tmeas <= 1'b0;
		for (int b = 0; b < 16; b++) begin
			@(posedge sys_clk_i);
			flags_i <= 16'h0001 << b;
			wr(`GLED_A_MASK, 16'h0001 << b);
			settle(3);
			e[0] = b inside {3, 5, 6, 7, 9};
			check("mask bit", 16'(a01_n), 16'(e[0]));
		end
		$display("test alert done");
	endtask
	task automatic t_four();
		int pct [5] = '{0, 25, 26, 67, 100};
		int e [5] = '{0, 1, 3, 7, 15};
		int n;
		wr(`GLED_A_LEDCFG, 16'h000A);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk_i);
			chg <= 7'(pct[i]);
			settle(4);
			check("four leds", 16'(leds4()), 16'(e[i]));
		end
		wr(`GLED_A_PACK, 16'h0001);
		settle(4);
		check("health", 16'(leds4()), 16'h0003);
		wr(`GLED_A_PACK, 16'h0002);
		settle(4);
		check("scaled", 16'({scaled, leds4()}), 16'h001F);
		wr(`GLED_A_LEDCFG, 16'h0002);
		settle(4);
		check("no press", 16'(leds4()), 16'h0000);
		wr(`GLED_A_TEST, 16'h0003);
		settle(4);
		check("test on", 16'(leds4()), 16'h000F);
		wr(`GLED_A_TEST, 16'h0001);
		settle(4);
		check("test off", 16'(leds4()), 16'h0000);
		wr(`GLED_A_TEST, 16'h0000);
		press(200, n);
		settle(4);
		check("short press", 16'(leds4()), 16'h0000);
		press(1100, n);
		check("press time", 16'(n >= 500 && n <= 1030), 16'h0001);
		settle(1400);
		check("still on", 16'(leds4()), 16'h000F);
		settle(700);
		check("timed off", 16'(leds4()), 16'h0000);
		$display("test four done");
	endtask
	task automatic t_single();
		int n;
		wr(`GLED_A_LEDCFG, 16'h0009);
		wr(`GLED_A_HOLD, 16'h0008);
		chg <= 7'd95;
		settle(600);
		count_hi(n);
		check("single idle", 16'(n), 16'd0);
		press(1100, n);
		count_hi(n);
		check("duty 90", 16'(n), 16'd360);
		@(posedge sys_clk_i);
		chg <= 7'd10;
		settle(4);
		count_hi(n);
		check("duty 10", 16'(n), 16'd40);
		$display("test single done");
	endtask
	task automatic t_ext();
		int cfg [5] = '{'h4B, 'h9C, 'h9B, 'hFB, 'hFB};
		int pct [5] = '{60, 60, 100, 100, 7};
		int e [5] = '{'h07, 'h3F, 'h3FF, 'hFFFF, 'h3};
		int m [5] = '{'hFF, 'hFFFF, 'hFFFF, 'hFFFF, 'hFFFF};
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk_i);
			chg <= 7'(pct[i]);
			wr(`GLED_A_LEDCFG, 16'(cfg[i]));
			settle(300);
			check("chain", chain & 16'(m[i]), 16'(e[i]));
			check("clock idle", 16'(sclk), 16'h0000);
		end
		$display("test external done");
	endtask
	task automatic t_flags();
		wr(`GLED_A_LEDCFG, 16'h0000);
		wr(`GLED_A_MASK, 16'h0200);
		flags_i <= 16'h0000;
		chg <= 7'd40;
		pulse(4'h8);
		rchk(`GLED_A_FLAGS, 16'h0200);
		check("full alert", 16'(a01_n), 16'h0000);
		pulse(4'h4);
		rchk(`GLED_A_FLAGS, 16'h0000);
		wr(`GLED_A_FCTH, 16'h0032);
		chg <= 7'd50;
		rchk(`GLED_A_FLAGS, 16'h0000);
		chg <= 7'd51;
		settle(3);
		rchk(`GLED_A_FLAGS, 16'h0200);
		pulse(4'h1);
		rchk(`GLED_A_FLAGS, 16'h0280);
		pulse(4'h2);
		rchk(`GLED_A_FLAGS, 16'h0200);
		@(posedge sys_clk_i);
		flags_i <= 16'hFFFF;
		chg <= 7'd40;
		pulse(4'h4);
		rchk(`GLED_A_FLAGS, 16'hFD17);
		$display("test flags done");
	endtask

	// ------------------------------------------
	// sequence, verdict and watchdog
	// ------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		srst_i = 1'b1;
		{wr_i, rd_i, btn, term, fclr, rent, rdone, tmeas} = 8'h00;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		flags_i = 16'h0000;
		chg = 7'd0;
		hlth = 7'd30;
		repeat (4) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_alert();
		t_four();
		t_single();
		t_ext();
		t_flags();
		conclude();
	end
	// the run needs about 7k cycles; 50k means a hang
	initial begin
		#500000;
		fail_count++;
		conclude();
	end
endmodule
